//--- verilog/lsfs_consts.svh
// constants of the led string fault supervisor
`ifndef LSFS_CONSTS_SVH
`define LSFS_CONSTS_SVH

// clock rate in MHz
`define LSFS_CLK_MHZ          250
// shortened open time-out above the lower temperature threshold, in microseconds
`define LSFS_FAST_TIMEOUT_US  800
`define LSFS_FAST_TIMEOUT_CYC (`LSFS_FAST_TIMEOUT_US * `LSFS_CLK_MHZ)
// output short decision delay after power-up, in milliseconds
`define LSFS_SHORT_DELAY_MS   31
`define LSFS_SHORT_DELAY_CYC  (`LSFS_SHORT_DELAY_MS * 1000 * `LSFS_CLK_MHZ)
// pwm periods a channel fault must persist
`define LSFS_PWM_TIMEOUTS     3'h6
// current steps: 100%, 75%, 50%, 25%
`define LSFS_STEP_FULL        2'h0
`define LSFS_STEP_QUARTER     2'h3
// sync vector field positions
`define LSFS_SV_EN            0
`define LSFS_SV_PWM           1
`define LSFS_SV_OTL           2
`define LSFS_SV_OTU           3
`define LSFS_SV_COOL          4
`define LSFS_SV_OVP           5
`define LSFS_SV_OVPL          6
`define LSFS_SV_LX            7
`define LSFS_SV_CH            8

`endif

//--- verilog/lsfs_pkg.sv
// types of the led string fault supervisor
package lsfs_pkg;
  typedef enum logic [1:0] {LSFS_OFF, LSFS_RUN, LSFS_OT_OFF, LSFS_LATCHED} lsfs_state_t;
  typedef logic [1:0] lsfs_step_t;
endpackage

//--- verilog/lsfs_chan_if.sv
// carrier between the supervisor and one channel monitor
interface lsfs_chan_if;
  logic ce;
  logic clear;
  logic active;
  logic pwm_tick;
  logic open_arm;
  logic fast;
  logic below;
  logic at_target;
  logic short_hi;
  logic on;
  logic fault;
  modport sup  (output ce, clear, active, pwm_tick, open_arm, fast, below, at_target, short_hi,
                input on, fault);
  modport chan (input ce, clear, active, pwm_tick, open_arm, fast, below, at_target, short_hi,
                output on, fault);
endinterface

//--- verilog/lsfs_sync.sv
// three-stage synchroniser that passes a bit once stages two and three agree
module lsfs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  input  wire logic         clk_en_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else if (clk_en_in)
    begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule // lsfs_sync

//--- verilog/lsfs_channel.sv
// per-channel good/open/short classification and time-out
`include "lsfs_consts.svh"
module lsfs_channel #(
  parameter int unsigned FAST_CYC = `LSFS_FAST_TIMEOUT_CYC
) (
  input  wire logic  clock_in,
  input  wire logic  reset_in,
  lsfs_chan_if.chan  ch
);
  localparam int unsigned FW = $clog2(FAST_CYC + 1);
  logic          good_q, good_d, on_q, on_d, flt_q, flt_d;
  logic [2:0]    cnt_q, cnt_d;
  logic [FW-1:0] fast_q, fast_d;
  logic          open_c, slow_c;

  always_comb
  begin
    open_c = ch.below & (good_q | ch.open_arm);
    slow_c = ch.short_hi | (open_c & ~ch.fast);
    good_d = good_q;
    on_d   = on_q;
    cnt_d  = cnt_q;
    fast_d = fast_q;
    flt_d  = 1'b0;
    if (ch.clear)
    begin
      good_d = 1'b0;
      on_d   = 1'b1;
      cnt_d  = 3'h0;
      fast_d = '0;
    end
    else if (on_q && ch.active)
    begin
      if (ch.at_target)
        good_d = 1'b1;
      if (!slow_c)
        cnt_d = 3'h0;
      else if (ch.pwm_tick)
        cnt_d = cnt_q + 3'h1;
      if (open_c && ch.fast)
        fast_d = fast_q + FW'(1);
      else
        fast_d = '0;
      // low channels without a short also time out once they were good or open_arm is set
      if (cnt_d == `LSFS_PWM_TIMEOUTS || fast_d == FW'(FAST_CYC))
      begin
        on_d  = 1'b0;
        flt_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      good_q <= 1'b0;
      on_q   <= 1'b1;
      flt_q  <= 1'b0;
      cnt_q  <= 3'h0;
      fast_q <= '0;
    end
    else if (ch.ce)
    begin
      good_q <= good_d;
      on_q   <= on_d;
      flt_q  <= flt_d;
      cnt_q  <= cnt_d;
      fast_q <= fast_d;
    end
  end

  assign ch.on    = on_q;
  assign ch.fault = flt_q;

  // ==========================================================================
  // checks
  property p_six_cycles;
    @(posedge clock_in) disable iff (reset_in)
    (ch.ce && !ch.clear && on_q && ch.active && ch.short_hi && ch.pwm_tick && cnt_q == 3'h5)
      |=> (!on_q && flt_q);
  endproperty
  a_six_cycles: assert property (p_six_cycles) else $error("short not timed out");

  property p_cnt_reset;
    @(posedge clock_in) disable iff (reset_in)
    (ch.ce && !ch.clear && on_q && ch.active && !ch.short_hi && !ch.below) |=> cnt_q == 3'h0;
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("count kept after fault left");

  property p_stay_on;
    @(posedge clock_in) disable iff (reset_in)
    (ch.ce && !ch.clear && on_q && !ch.short_hi && !ch.below) |=> on_q;
  endproperty
  a_stay_on: assert property (p_stay_on) else $error("healthy channel dropped");

  c_chan_off: cover property (@(posedge clock_in) disable iff (reset_in) flt_q);
endmodule // lsfs_channel

//--- verilog/lsfs_supervisor.sv
// led string fault supervisor: temperature, channel, overvoltage and output-short protection
`include "lsfs_consts.svh"
module lsfs_supervisor #(
  parameter int unsigned NUM_CH    = 6,
  parameter int unsigned FAST_CYC  = `LSFS_FAST_TIMEOUT_CYC,
  parameter int unsigned SHORT_CYC = `LSFS_SHORT_DELAY_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  input  wire logic              clk_en_in,
  input  wire logic              enable_in,
  input  wire logic              pwm_period_in,
  input  wire logic              temp_lower_in,
  input  wire logic              temp_upper_in,
  input  wire logic              temp_cooled_in,
  input  wire logic              output_overvoltage_limit_in,
  input  wire logic              ovp_sense_low_in,
  input  wire logic              boost_switch_node_fault_in,
  input  wire logic [NUM_CH-1:0] chan_below_target_in,
  input  wire logic [NUM_CH-1:0] chan_at_target_in,
  input  wire logic [NUM_CH-1:0] channel_pin_voltage_high_in,
  output logic      [NUM_CH-1:0] channel_enable_out,
  output logic                   boost_enable_out,
  output logic      [1:0]        current_step_out,
  output logic                   fault_flag_n_out,
  output logic                   fault_flag_oe_out,
  output logic                   shutdown_latched_out
);
  localparam int unsigned SW = 3 * NUM_CH + 8;
  localparam int unsigned TW = $clog2(SHORT_CYC + 1);

  // ==========================================================================
  // input synchronisation
  logic [SW-1:0]     async_v;
  logic [SW-1:0]     sync_v;
  logic              en_s, pwm_s, otl_s, otu_s, cool_s, ovp_s, ovpl_s, lx_s;
  logic [NUM_CH-1:0] below_s, at_s, hi_s;

  assign async_v = {channel_pin_voltage_high_in, chan_at_target_in, chan_below_target_in,
                    boost_switch_node_fault_in, ovp_sense_low_in, output_overvoltage_limit_in,
                    temp_cooled_in, temp_upper_in, temp_lower_in, pwm_period_in, enable_in};

  lsfs_sync #(
    .W (SW)
  ) u_sync (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .async_in  (async_v),
    .sync_out  (sync_v)
  );

  assign en_s    = sync_v[`LSFS_SV_EN];
  assign pwm_s   = sync_v[`LSFS_SV_PWM];
  assign otl_s   = sync_v[`LSFS_SV_OTL];
  assign otu_s   = sync_v[`LSFS_SV_OTU];
  assign cool_s  = sync_v[`LSFS_SV_COOL];
  assign ovp_s   = sync_v[`LSFS_SV_OVP];
  assign ovpl_s  = sync_v[`LSFS_SV_OVPL];
  assign lx_s    = sync_v[`LSFS_SV_LX];
  assign below_s = sync_v[`LSFS_SV_CH +: NUM_CH];
  assign at_s    = sync_v[`LSFS_SV_CH + NUM_CH +: NUM_CH];
  assign hi_s    = sync_v[`LSFS_SV_CH + 2 * NUM_CH +: NUM_CH];

  // ==========================================================================
  // supervisor state
  lsfs_pkg::lsfs_state_t state_q, state_d;
  lsfs_pkg::lsfs_step_t  step_q, step_d;
  logic                  flag_q, flag_d;
  logic                  seen_q, seen_d;
  logic                  arm_q, arm_d;
  logic                  pwm_prev_q, pwm_prev_d;
  logic                  up_prev_q, up_prev_d;
  logic [TW-1:0]         tmr_q, tmr_d;
  logic                  tmr_done, short_ind, pwm_tick;
  logic [NUM_CH-1:0]     on_v, fault_v;

  assign tmr_done = (tmr_q == TW'(SHORT_CYC));
  assign pwm_tick = pwm_s & ~pwm_prev_q;
  // a collapse of the sense only counts once it has been above the dip level
  assign short_ind = lx_s | (arm_q & ovpl_s);

  always_comb
  begin
    state_d    = state_q;
    step_d     = step_q;
    flag_d     = flag_q;
    seen_d     = seen_q;
    arm_d      = arm_q;
    tmr_d      = tmr_q;
    pwm_prev_d = pwm_s;
    up_prev_d  = otu_s;
    if (!en_s && state_q != lsfs_pkg::LSFS_LATCHED)
    begin
      // re-enable restarts everything except a permanent shutdown
      state_d = lsfs_pkg::LSFS_OFF;
      step_d  = `LSFS_STEP_FULL;
      flag_d  = 1'b0;
      seen_d  = 1'b0;
      arm_d   = 1'b0;
      tmr_d   = '0;
    end
    else
    begin
      flag_d = flag_q | (|fault_v) | short_ind | ovp_s | (otu_s & ~up_prev_q);
      if (!ovpl_s)
        arm_d = 1'b1;
      if (short_ind)
        seen_d = 1'b1;
      if (!tmr_done)
        tmr_d = tmr_q + TW'(1);
      unique case (state_q)
        lsfs_pkg::LSFS_OFF:
          state_d = lsfs_pkg::LSFS_RUN;
        lsfs_pkg::LSFS_RUN:
          if (seen_q && tmr_done)
            state_d = lsfs_pkg::LSFS_LATCHED;
          else if (otu_s)
          begin
            state_d = lsfs_pkg::LSFS_OT_OFF;
            if (step_q != `LSFS_STEP_QUARTER)
              step_d = step_q + 2'h1;
          end
        lsfs_pkg::LSFS_OT_OFF:
          if (seen_q && tmr_done)
            state_d = lsfs_pkg::LSFS_LATCHED;
          else if (cool_s && !otu_s)
            state_d = lsfs_pkg::LSFS_RUN;
        lsfs_pkg::LSFS_LATCHED:
          state_d = lsfs_pkg::LSFS_LATCHED;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q    <= lsfs_pkg::LSFS_OFF;
      step_q     <= `LSFS_STEP_FULL;
      flag_q     <= 1'b0;
      seen_q     <= 1'b0;
      arm_q      <= 1'b0;
      pwm_prev_q <= 1'b0;
      up_prev_q  <= 1'b0;
      tmr_q      <= '0;
    end
    else if (clk_en_in)
    begin
      state_q    <= state_d;
      step_q     <= step_d;
      flag_q     <= flag_d;
      seen_q     <= seen_d;
      arm_q      <= arm_d;
      pwm_prev_q <= pwm_prev_d;
      up_prev_q  <= up_prev_d;
      tmr_q      <= tmr_d;
    end
  end

  // ==========================================================================
  // channel monitors
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    lsfs_chan_if u_if ();
    assign u_if.ce        = clk_en_in;
    assign u_if.clear     = (state_q == lsfs_pkg::LSFS_OFF);
    assign u_if.active    = (state_q == lsfs_pkg::LSFS_RUN);
    assign u_if.pwm_tick  = pwm_tick;
    assign u_if.open_arm  = ovp_s | otl_s;
    assign u_if.fast      = otl_s;
    assign u_if.below     = below_s[i];
    assign u_if.at_target = at_s[i];
    assign u_if.short_hi  = hi_s[i];
    assign on_v[i]        = u_if.on;
    assign fault_v[i]     = u_if.fault;

    lsfs_channel #(
      .FAST_CYC (FAST_CYC)
    ) u_ch (
      .clock_in (clock_in),
      .reset_in (reset_in),
      .ch       (u_if.chan)
    );
  end

  // ==========================================================================
  // outputs
  // all current sources are forced off while the boost is off
  assign channel_enable_out   = boost_enable_out ? on_v : '0;
  assign boost_enable_out     = (state_q == lsfs_pkg::LSFS_RUN);
  assign current_step_out     = step_q;
  assign fault_flag_n_out     = 1'b0;
  assign fault_flag_oe_out    = flag_q;
  assign shutdown_latched_out = (state_q == lsfs_pkg::LSFS_LATCHED);

  // ==========================================================================
  // checks
  property p_ot_off;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && state_q == lsfs_pkg::LSFS_RUN && otu_s && !(seen_q && tmr_done))
      |=> (!boost_enable_out && channel_enable_out == '0);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("upper trip did not stop output");

  property p_restart;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && state_q == lsfs_pkg::LSFS_OT_OFF && cool_s && !otu_s
     && !(seen_q && tmr_done)) |=> boost_enable_out;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after cooling");

  property p_step;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && state_q == lsfs_pkg::LSFS_RUN && otu_s && !(seen_q && tmr_done)
     && step_q != 2'h3) |=> current_step_out == $past(step_q) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("current not stepped down");

  property p_floor;
    @(posedge clock_in) disable iff (reset_in)
    (en_s && step_q == 2'h3) |=> (current_step_out == 2'h3 || !$past(en_s, 1) || !en_s);
  endproperty
  a_floor: assert property (p_floor) else $error("current left lowest step");

  property p_active;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s) |=> state_q != lsfs_pkg::LSFS_OFF;
  endproperty
  a_active: assert property (p_active) else $error("enabled device went idle");

  property p_flag_hold;
    @(posedge clock_in) disable iff (reset_in)
    (flag_q && en_s) |=> fault_flag_oe_out;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("fault flag dropped");

  property p_flag_set;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && (|fault_v)) |=> fault_flag_oe_out;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("channel fault not flagged");

  property p_latch;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && state_q == lsfs_pkg::LSFS_RUN && seen_q && tmr_done)
      |=> shutdown_latched_out ##1 shutdown_latched_out;
  endproperty
  a_latch: assert property (p_latch) else $error("output short not latched off");

  property p_dip;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && arm_q && ovpl_s) |=> (seen_q && fault_flag_oe_out);
  endproperty
  a_dip: assert property (p_dip) else $error("sense dip not recorded");

  property p_dis_clear;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !en_s && state_q != lsfs_pkg::LSFS_LATCHED)
      |=> (!fault_flag_oe_out && current_step_out == 2'h0 && !boost_enable_out);
  endproperty
  a_dis_clear: assert property (p_dis_clear) else $error("disable did not clear");

  property p_no_early_latch;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !tmr_done && state_q != lsfs_pkg::LSFS_LATCHED) |=> !shutdown_latched_out;
  endproperty
  a_no_early_latch: assert property (p_no_early_latch) else $error("latched too early");

  property p_ot_hold;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && state_q == lsfs_pkg::LSFS_OT_OFF && otu_s && !(seen_q && tmr_done))
      |=> (state_q == lsfs_pkg::LSFS_OT_OFF && current_step_out == $past(step_q));
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("hot state left or stepped");

  property p_ot_flag;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && otu_s && !up_prev_q) |=> fault_flag_oe_out;
  endproperty
  a_ot_flag: assert property (p_ot_flag) else $error("upper trip not flagged");

  property p_ovp_flag;
    @(posedge clock_in) disable iff (reset_in)
    (clk_en_in && en_s && ovp_s) |=> fault_flag_oe_out;
  endproperty
  a_ovp_flag: assert property (p_ovp_flag) else $error("overvoltage not flagged");

  property p_latched_stay;
    @(posedge clock_in) disable iff (reset_in)
    shutdown_latched_out |=> shutdown_latched_out;
  endproperty
  a_latched_stay: assert property (p_latched_stay) else $error("shutdown released");

  c_ot_cycle: cover property (@(posedge clock_in) disable iff (reset_in)
    state_q == lsfs_pkg::LSFS_OT_OFF ##1 state_q == lsfs_pkg::LSFS_RUN);
  c_quarter: cover property (@(posedge clock_in) disable iff (reset_in) step_q == 2'h3);
  c_latched: cover property (@(posedge clock_in) disable iff (reset_in) shutdown_latched_out);
endmodule // lsfs_supervisor

//--- sim/lsfs_led_model.sv
// behavioural led strings and boost sense comparators facing the supervisor
module lsfs_led_model (
  input  wire logic       clock_in,
  input  wire logic [5:0] chan_en_in,
  input  wire logic       boost_en_in,
  input  wire logic [5:0] open_in,
  input  wire logic [5:0] weak_in,
  input  wire logic [5:0] short_in,
  output logic      [5:0] below_out,
  output logic      [5:0] at_target_out,
  output logic      [5:0] pin_high_out,
  output logic            ovp_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // comparators
  // a dark string draws nothing, so it reads below target only while driven
  always_ff @(posedge clock_in)
  begin
    below_out     <= chan_en_in & (open_in | weak_in);
    at_target_out <= chan_en_in & ~(open_in | weak_in) & {6{boost_en_in}};
    pin_high_out  <= chan_en_in & short_in;
    // only a truly open string lets the output climb to the limit
    ovp_out       <= boost_en_in & (|(chan_en_in & open_in));
  end
endmodule // lsfs_led_model

//--- sim/led_string_fault_supervisor_tb_top.sv
// self-checking bench of the led string fault supervisor
module led_string_fault_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       clk_en = 1'h1;
  logic       enable, pwm, t_low, t_up, t_cool, ovp_low, sw_fault;
  logic [5:0] open_m, weak_m, short_m, below, at_tgt, pin_hi, ch_en, exp_en;
  logic       output_overvoltage_limit, boost, flag_n, flag_oe, latched;
  logic [1:0] step;
  logic [7:0] rnd;
  int         n_mismatch = 0;
  int         checked = 0;
  int         cycles = 0;
  int         sc, oc, lc;

  lsfs_supervisor #(.NUM_CH(6), .FAST_CYC(20), .SHORT_CYC(200)) lsfs_supervisor_i (
    .clock_in                    (clock),
    .reset_in                    (reset),
    .clk_en_in                   (clk_en),
    .enable_in                   (enable),
    .pwm_period_in               (pwm),
    .temp_lower_in               (t_low),
    .temp_upper_in               (t_up),
    .temp_cooled_in              (t_cool),
    .output_overvoltage_limit_in (output_overvoltage_limit),
    .ovp_sense_low_in            (ovp_low),
    .boost_switch_node_fault_in  (sw_fault),
    .chan_below_target_in        (below),
    .chan_at_target_in           (at_tgt),
    .channel_pin_voltage_high_in (pin_hi),
    .channel_enable_out          (ch_en),
    .boost_enable_out            (boost),
    .current_step_out            (step),
    .fault_flag_n_out            (flag_n),
    .fault_flag_oe_out           (flag_oe),
    .shutdown_latched_out        (latched)
  );

  lsfs_led_model lsfs_led_model_i (
    .clock_in      (clock),
    .chan_en_in    (ch_en),
    .boost_en_in   (boost),
    .open_in       (open_m),
    .weak_in       (weak_m),
    .short_in      (short_m),
    .below_out     (below),
    .at_target_out (at_tgt),
    .pin_high_out  (pin_hi),
    .ovp_out       (output_overvoltage_limit)
  );

  always #2 clock = ~clock;

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // current step saturates at the quarter setting
  function automatic logic [1:0] exp_step(input int n);
    return (n > 3) ? 2'h3 : n[1:0];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // each pulse is held long enough to survive the synchroniser
  task automatic ticks(input int n);
    repeat (n)
    begin
      pwm = 1'b1;
      cyc(6);
      pwm = 1'b0;
      cyc(6);
    end
  endtask

  task automatic wait_boost;
    for (int k = 0; k < 40 && boost !== 1'b1; k++) @(negedge clock);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {enable, pwm, t_low, t_up, t_cool, ovp_low, sw_fault} = 7'h40;
    {open_m, weak_m, short_m} = 18'h0;
    rnd = lfsr(8'h39);
    sc = rnd % 6;
    oc = (sc + 1) % 6;
    lc = (sc + 2) % 6;
    // weak from the start, so this string is never marked good
    weak_m[lc] = 1'b1;
    cyc(16);
    reset = 1'b0;
    wait_boost();
    cyc(4);
    exp_en = 6'h3F;
    chk(boost, 1, "boost on");
    chk(ch_en, exp_en, "all on");
    chk({flag_n, flag_oe, step}, 0, "idle flag");
    // a frozen clock enable must hide a short drop of enable
    clk_en = 1'h0;
    enable = 1'h0;
    cyc(12);
    chk({boost, ch_en}, {1'h1, exp_en}, "frozen");
    enable = 1'h1;
    cyc(2);
    clk_en = 1'h1;
    ticks(8);
    chk(ch_en, exp_en, "weak never good");
    t_low = 1'b1;
    cyc(12);
    chk(ch_en, exp_en, "fast timeout early");
    cyc(20);
    exp_en[lc] = 1'b0;
    chk(ch_en, exp_en, "hot weak off");
    chk(flag_oe, 1, "open flag");
    t_low = 1'b0;
    weak_m = 6'h0;
    short_m[sc] = 1'b1;
    // comparators lag short_m by one edge: settle before the first period
    cyc(2);
    ticks(5);
    short_m[sc] = 1'b0;
    cyc(8);
    short_m[sc] = 1'b1;
    cyc(2);
    ticks(5);
    chk(ch_en, exp_en, "count restarted");
    ticks(1);
    exp_en[sc] = 1'b0;
    chk(ch_en, exp_en, "short off");
    short_m = 6'h0;
    open_m[oc] = 1'b1;
    cyc(2);
    ticks(5);
    chk(ch_en, exp_en, "open waits");
    ticks(1);
    exp_en[oc] = 1'b0;
    chk(ch_en, exp_en, "open off");
    open_m = 6'h0;
    for (int i = 1; i <= 4; i++)
    begin
      t_up = 1'b1;
      cyc(8);
      chk({boost, ch_en}, 0, "hot stop");
      chk(step, exp_step(i), "step down");
      t_up = 1'b0;
      t_cool = 1'b1;
      cyc(8);
      t_cool = 1'b0;
      cyc(4);
      chk({boost, ch_en}, {1'b1, exp_en}, "restart");
    end
    enable = 1'b0;
    cyc(8);
    chk({boost, flag_oe, step}, 0, "disabled");
    enable = 1'b1;
    wait_boost();
    cyc(4);
    chk(ch_en, 6'h3F, "re-enabled");
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        ovp_low = 1'b1;
      else
        sw_fault = 1'b1;
      cyc(40);
      chk(latched, 0, "short waits");
      for (int j = 0; j < 400 && latched !== 1'b1; j++) @(negedge clock);
      chk({latched, boost, ch_en, flag_oe}, 9'h101, "latched");
      enable = 1'b0;
      cyc(8);
      enable = 1'b1;
      cyc(12);
      chk(latched, 1, "stays latched");
      {ovp_low, sw_fault} = 2'h0;
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      wait_boost();
      chk({latched, boost}, 2'h1, "reset clears");
    end
    results();
  end
endmodule // led_string_fault_supervisor_tb_top
